// ===== ocie_consts.svh
// Constants of the oscillator-controller interrupt-enable block.
// Assumes inclusion by bare name from the package and the top module.
`ifndef OCIE_CONSTS_SVH
`define OCIE_CONSTS_SVH

`define OCIE_DATA_W 32
`define OCIE_ADDR_W 4
`define OCIE_BE_W 4
`define OCIE_LANE_W 8

// Register byte offsets
`define OCIE_OFS_CLR 4'h0
`define OCIE_OFS_SET 4'h4
`define OCIE_OFS_STAT 4'h8
`define OCIE_OFS_MASK 4'hc

// Implemented bits 17:15 and 11:0
`define OCIE_IMPL_MASK 32'h0003_8fff
`define OCIE_ENABLE_RESET 32'h0000_0000
`define OCIE_STATUS_RESET 32'h0000_0000
`define OCIE_MASK_RESET 32'h0003_8fff
`define OCIE_ZERO 32'h0000_0000

// Enable bit positions
`define OCIE_BIT_PLL_LTO 17
`define OCIE_BIT_PLL_LCKF 16
`define OCIE_BIT_PLL_LCKR 15
`define OCIE_BIT_BOD_SRDY 11
`define OCIE_BIT_BOD_DET 10
`define OCIE_BIT_BOD_RDY 9
`define OCIE_BIT_FLL_RCS 8
`define OCIE_BIT_FLL_LCKC 7
`define OCIE_BIT_FLL_LCKF 6
`define OCIE_BIT_FLL_OOB 5
`define OCIE_BIT_FLL_RDY 4
`define OCIE_BIT_RC8M 3
`define OCIE_BIT_RC32K 2
`define OCIE_BIT_XTAL32K 1
`define OCIE_BIT_XTAL 0

`endif

// ===== ocie_pkg.sv
// Types of the oscillator-controller interrupt-enable block.
// Assumes ocie_consts.svh is on the include path.
`include "ocie_consts.svh"

package ocie_pkg;

  // Enable / status / mask layout, bit 31 first
  typedef struct packed {
    logic [13:0] rsv_hi;
    logic pll_lock_timeout_ie;
    logic pll_lock_fall_ie;
    logic pll_lock_rise_ie;
    logic [2:0] rsv_mid;
    logic brownout_sync_ready_ie;
    logic brownout_detect_ie;
    logic brownout_ready_ie;
    logic fll_ref_stopped_ie;
    logic fll_coarse_lock_ie;
    logic fll_fine_lock_ie;
    logic fll_out_of_bounds_ie;
    logic fll_ready_ie;
    logic rc8m_ready_ie;
    logic rc32k_ready_ie;
    logic xtal32k_ready_ie;
    logic xtal_main_ready_ie;
  } ocie_ie_t;

  typedef struct packed {
    logic [`OCIE_ADDR_W-1:0] address;
    logic read;
    logic write;
    logic [`OCIE_DATA_W-1:0] writedata;
    logic [`OCIE_BE_W-1:0] byteenable;
  } ocie_avreq_t;

  typedef struct packed {
    ocie_ie_t enable;
    ocie_ie_t status;
    ocie_ie_t mask;
    logic [`OCIE_DATA_W-1:0] rdata;
    logic waitreq;
    logic [`OCIE_DATA_W-1:0] req;
    logic irq;
    logic evt_irq;
  } ocie_state_t;

endpackage

// ===== ocie_top.sv
// Interrupt-enable clear/set registers with source gating and interrupt outputs.
// Assumes an Avalon-MM master on CLK and source flags from logic on CLK.
//
// Chosen here: the Avalon-MM slave port.
`timescale 1ns/1ns
`include "ocie_consts.svh"

// Behaviour
// - Byte, halfword and word accesses each complete as one indivisible operation.
// - Every byte lane and halfword is individually writable and readable.
// - Writes to the enable registers are ignored while access protection is active.
// - Writing one to a clear-register bit clears that shared enable.
// - Writing zero through the clear register leaves the enable unchanged.
// - Clear and set registers read back the same shared enable bits.
// - Reserved bits 31:18 and 14:12 are read-only and read as zero.
// - A source requests an interrupt while its enable and flag are both one.
// - PLL enables sit at bits 17 timeout, 16 lock lost, 15 lock gained.
// - Brown-out enables sit at bits 11 sync ready, 10 detect, 9 ready.
// - FLL enables sit at bits 8 ref stopped, 7 coarse, 6 fine, 5 bounds, 4 ready.
// - Oscillator enables sit at bits 3 rc8m, 2 rc32k, 1 xtal32k, 0 main xtal.
// - Writing one to a set-register bit sets that shared enable; zero leaves it.
module ocie_top
  import ocie_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic CE,
  input wire logic [`OCIE_ADDR_W-1:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [`OCIE_DATA_W-1:0] AVS_WRITEDATA,
  input wire logic [`OCIE_BE_W-1:0] AVS_BYTEENABLE,
  output logic [`OCIE_DATA_W-1:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic PROT_ACTIVE,
  input wire logic [`OCIE_DATA_W-1:0] SRC_FLAG,
  output logic [`OCIE_DATA_W-1:0] IRQ_REQ,
  output logic IRQ,
  output logic EVT_IRQ
);

  //----------------------------------------------------------------
  // Bus request and byte-lane mask
  //----------------------------------------------------------------
  ocie_avreq_t bus;
  ocie_state_t st;
  ocie_state_t next_st;
  logic [`OCIE_DATA_W-1:0] wmask;
  logic [`OCIE_DATA_W-1:0] wbits;
  logic [`OCIE_DATA_W-1:0] req_now;
  logic [`OCIE_DATA_W-1:0] rd_mux;
  logic done_write;
  logic take_req;

  assign bus = '{address: AVS_ADDRESS, read: AVS_READ, write: AVS_WRITE,
                 writedata: AVS_WRITEDATA, byteenable: AVS_BYTEENABLE};

  genvar lane;
  generate
    for (lane = 0; lane < `OCIE_BE_W; lane++) begin : g_lane
      assign wmask[`OCIE_LANE_W*lane +: `OCIE_LANE_W] = {`OCIE_LANE_W{bus.byteenable[lane]}};
    end
  endgenerate

  // Only implemented bits of enabled lanes can change
  assign wbits = bus.writedata & wmask & `OCIE_IMPL_MASK;
  assign req_now = st.enable & SRC_FLAG & `OCIE_IMPL_MASK;
  // Write takes effect at the edge where waitrequest is seen low
  assign done_write = CE && !st.waitreq && bus.write;
  assign take_req = CE && st.waitreq && (bus.read || bus.write);

  //----------------------------------------------------------------
  // Read mux
  //----------------------------------------------------------------
  always_comb begin
    unique case (bus.address)
      `OCIE_OFS_CLR: rd_mux = st.enable;
      `OCIE_OFS_SET: rd_mux = st.enable;
      `OCIE_OFS_STAT: rd_mux = st.status;
      `OCIE_OFS_MASK: rd_mux = st.mask;
      default: rd_mux = `OCIE_ZERO;
    endcase
  end

  //----------------------------------------------------------------
  // Next state
  //----------------------------------------------------------------
  always_comb begin
    next_st = st;
    if (CE) begin
      next_st.waitreq = 1'b1;
      if (take_req) begin
        next_st.waitreq = 1'b0;
        if (bus.read) begin
          next_st.rdata = rd_mux & `OCIE_IMPL_MASK;
        end
      end
      next_st.status = st.status | req_now;
      if (done_write) begin
        unique case (bus.address)
          `OCIE_OFS_CLR: begin
            if (!PROT_ACTIVE) begin
              next_st.enable = st.enable & ~wbits;
            end
          end
          `OCIE_OFS_SET: begin
            if (!PROT_ACTIVE) begin
              next_st.enable = st.enable | wbits;
            end
          end
          `OCIE_OFS_STAT: begin
            // New event wins over a clear in the same cycle
            next_st.status = (st.status & ~wbits) | req_now;
          end
          `OCIE_OFS_MASK: begin
            next_st.mask = (st.mask & ~(wmask & `OCIE_IMPL_MASK)) | wbits;
          end
          default: begin
            next_st.mask = st.mask;
          end
        endcase
      end
      next_st.req = req_now;
      next_st.irq = |req_now;
      next_st.evt_irq = |(next_st.status & next_st.mask);
    end
  end

  //----------------------------------------------------------------
  // State register
  //----------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      st.enable <= `OCIE_ENABLE_RESET;
      st.status <= `OCIE_STATUS_RESET;
      st.mask <= `OCIE_MASK_RESET;
      st.rdata <= `OCIE_ZERO;
      st.waitreq <= 1'b1;
      st.req <= `OCIE_ZERO;
      st.irq <= 1'b0;
      st.evt_irq <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  assign AVS_READDATA = st.rdata;
  assign AVS_WAITREQUEST = st.waitreq;
  assign IRQ_REQ = st.req;
  assign IRQ = st.irq;
  assign EVT_IRQ = st.evt_irq;

  //----------------------------------------------------------------
  // Checks
  //----------------------------------------------------------------
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);

  AST_ACK_ONE_CYCLE: assert property (
    take_req |=> !AVS_WAITREQUEST ##1 (AVS_WAITREQUEST || !$past(CE)))
    else $error("Request not acknowledged for exactly one cycle");

  AST_ACK_AFTER_REQ: assert property (
    $fell(AVS_WAITREQUEST) |-> $past(AVS_READ || AVS_WRITE) && $past(CE))
    else $error("Waitrequest dropped without a request");

  AST_IDLE_WAITS: assert property (
    CE && !AVS_READ && !AVS_WRITE && AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("Waitrequest dropped with no request pending");

  AST_WAIT_HOLDS_DATA: assert property (
    AVS_WAITREQUEST && $past(RST_N) |-> $stable(AVS_READDATA))
    else $error("Read data changed while no read was answered");

  AST_RESET_OUTPUTS: assert property (disable iff (1'b0)
    !RST_N |=> AVS_WAITREQUEST && !IRQ && !EVT_IRQ
      && IRQ_REQ == `OCIE_ZERO && AVS_READDATA == `OCIE_ZERO)
    else $error("Outputs not at their reset values after reset");

  AST_RESET_REGS: assert property (disable iff (1'b0)
    !RST_N |=> st.enable == `OCIE_ENABLE_RESET && st.status == `OCIE_STATUS_RESET
      && st.mask == `OCIE_MASK_RESET)
    else $error("Registers not at their reset values after reset");

  AST_UNMAPPED_ZERO: assert property (
    take_req && bus.read && bus.address != `OCIE_OFS_CLR && bus.address != `OCIE_OFS_SET
    && bus.address != `OCIE_OFS_STAT && bus.address != `OCIE_OFS_MASK
    |=> AVS_READDATA == `OCIE_ZERO)
    else $error("Unmapped read returned nonzero data");

  AST_STATUS_W1C: assert property (
    done_write && bus.address == `OCIE_OFS_STAT
    |=> (st.status & $past(wbits) & ~$past(req_now)) == `OCIE_ZERO)
    else $error("Status bit written with one stayed set without a new event");

  AST_MASK_WRITE: assert property (
    done_write && bus.address == `OCIE_OFS_MASK
    |=> (st.mask & $past(wmask) & `OCIE_IMPL_MASK) == $past(wbits))
    else $error("Mask write did not take the written lanes");

  AST_LANE_KEEP: assert property (
    done_write && bus.address == `OCIE_OFS_MASK
    |=> (st.mask & ~$past(wmask)) == ($past(st.mask) & ~$past(wmask)))
    else $error("Mask write disturbed a disabled byte lane");

  AST_PROT_BLOCKS: assert property (
    done_write && PROT_ACTIVE
    && (bus.address == `OCIE_OFS_CLR || bus.address == `OCIE_OFS_SET)
    |=> st.enable == $past(st.enable))
    else $error("Protected write changed an enable");

  AST_CLR_ONES: assert property (
    done_write && !PROT_ACTIVE && bus.address == `OCIE_OFS_CLR
    |=> (st.enable & $past(wbits)) == `OCIE_ZERO)
    else $error("Clear write left an enable set");

  AST_CLR_ZEROS: assert property (
    done_write && !PROT_ACTIVE && bus.address == `OCIE_OFS_CLR
    |=> (st.enable & ~$past(wbits)) == ($past(st.enable) & ~$past(wbits)))
    else $error("Clear write changed an enable written with zero");

  AST_MIRROR_READ: assert property (
    take_req && bus.read
    && (bus.address == `OCIE_OFS_CLR || bus.address == `OCIE_OFS_SET)
    |=> AVS_READDATA == $past(st.enable))
    else $error("Enable read returned a value other than the shared enables");

  AST_RSV_ZERO: assert property (
    ((AVS_READDATA | st.enable) & ~`OCIE_IMPL_MASK) == `OCIE_ZERO)
    else $error("Reserved bit read or held as one");

  AST_RSV_STATE: assert property (
    ((st.status | st.mask | IRQ_REQ) & ~`OCIE_IMPL_MASK) == `OCIE_ZERO)
    else $error("Reserved bit held as one in status, mask or requests");

  AST_REQ_GATE: assert property (
    CE |=> IRQ_REQ == ($past(st.enable) & $past(SRC_FLAG) & `OCIE_IMPL_MASK))
    else $error("Request does not follow enable and flag");

  AST_NO_ENABLE_NO_REQ: assert property (
    CE |=> (IRQ_REQ & ~$past(st.enable)) == `OCIE_ZERO)
    else $error("Request raised for a disabled source");

  AST_PLL_FIELDS: assert property (
    CE |=> IRQ_REQ[`OCIE_BIT_PLL_LTO] == $past(st.enable.pll_lock_timeout_ie
      && SRC_FLAG[`OCIE_BIT_PLL_LTO])
      && IRQ_REQ[`OCIE_BIT_PLL_LCKF] == $past(st.enable.pll_lock_fall_ie
      && SRC_FLAG[`OCIE_BIT_PLL_LCKF])
      && IRQ_REQ[`OCIE_BIT_PLL_LCKR] == $past(st.enable.pll_lock_rise_ie
      && SRC_FLAG[`OCIE_BIT_PLL_LCKR]))
    else $error("PLL enable field out of place");

  AST_BOD_FIELDS: assert property (
    CE |=> IRQ_REQ[`OCIE_BIT_BOD_SRDY] == $past(st.enable.brownout_sync_ready_ie
      && SRC_FLAG[`OCIE_BIT_BOD_SRDY])
      && IRQ_REQ[`OCIE_BIT_BOD_DET] == $past(st.enable.brownout_detect_ie
      && SRC_FLAG[`OCIE_BIT_BOD_DET])
      && IRQ_REQ[`OCIE_BIT_BOD_RDY] == $past(st.enable.brownout_ready_ie
      && SRC_FLAG[`OCIE_BIT_BOD_RDY]))
    else $error("Brown-out enable field out of place");

  AST_FLL_FIELDS: assert property (
    CE |=> IRQ_REQ[`OCIE_BIT_FLL_RCS] == $past(st.enable.fll_ref_stopped_ie
      && SRC_FLAG[`OCIE_BIT_FLL_RCS])
      && IRQ_REQ[`OCIE_BIT_FLL_LCKC] == $past(st.enable.fll_coarse_lock_ie
      && SRC_FLAG[`OCIE_BIT_FLL_LCKC])
      && IRQ_REQ[`OCIE_BIT_FLL_LCKF] == $past(st.enable.fll_fine_lock_ie
      && SRC_FLAG[`OCIE_BIT_FLL_LCKF])
      && IRQ_REQ[`OCIE_BIT_FLL_OOB] == $past(st.enable.fll_out_of_bounds_ie
      && SRC_FLAG[`OCIE_BIT_FLL_OOB])
      && IRQ_REQ[`OCIE_BIT_FLL_RDY] == $past(st.enable.fll_ready_ie
      && SRC_FLAG[`OCIE_BIT_FLL_RDY]))
    else $error("FLL enable field out of place");

  AST_OSC_FIELDS: assert property (
    CE |=> IRQ_REQ[`OCIE_BIT_RC8M] == $past(st.enable.rc8m_ready_ie
      && SRC_FLAG[`OCIE_BIT_RC8M])
      && IRQ_REQ[`OCIE_BIT_RC32K] == $past(st.enable.rc32k_ready_ie
      && SRC_FLAG[`OCIE_BIT_RC32K])
      && IRQ_REQ[`OCIE_BIT_XTAL32K] == $past(st.enable.xtal32k_ready_ie
      && SRC_FLAG[`OCIE_BIT_XTAL32K])
      && IRQ_REQ[`OCIE_BIT_XTAL] == $past(st.enable.xtal_main_ready_ie
      && SRC_FLAG[`OCIE_BIT_XTAL]))
    else $error("Oscillator enable field out of place");

  AST_SET_ONES: assert property (
    done_write && !PROT_ACTIVE && bus.address == `OCIE_OFS_SET
    |=> (st.enable & $past(wbits)) == $past(wbits)
      && (st.enable & ~$past(wbits)) == ($past(st.enable) & ~$past(wbits)))
    else $error("Set write did not set exactly the written enables");

  AST_IRQ_OR: assert property (
    CE |=> IRQ == (|IRQ_REQ))
    else $error("Interrupt output differs from OR of requests");

  AST_EVENT_STICKY: assert property (
    CE && req_now != `OCIE_ZERO
    |=> (st.status & $past(req_now)) == $past(req_now))
    else $error("Event lost against a status clear");

  AST_EVT_IRQ: assert property (
    CE |=> EVT_IRQ == (|(st.status & st.mask)))
    else $error("Event interrupt does not follow status and mask");

  AST_FREEZE: assert property (
    !CE |=> st == $past(st))
    else $error("State changed while clock enable low");

endmodule

// ===== ocie_src_model.sv
// Model of the interrupt sources that feed the enable block.
// Assumes the bench sets the wanted flags; they reach the block one edge later.
`timescale 1ns/1ns
module ocie_src_model
  import ocie_pkg::*;
(
  input wire logic clk,
  input wire logic [31:0] flag_req,
  output logic [31:0] flag
);
  // Flags move only after an edge, as the real sources do
  always_ff @(posedge clk) begin
    flag <= flag_req;
  end
endmodule

// ===== osc_ctrl_interrupt_enable_tb_top.sv
// Self-checking bench of the interrupt-enable block against a behavioural model.
// Assumes ocie_top, ocie_src_model and the package are compiled first.
`timescale 1ns/1ns
`include "ocie_consts.svh"
module osc_ctrl_interrupt_enable_tb_top import ocie_pkg::*;;
  localparam logic [31:0] impl = 32'h0003_8fff;
  logic clk = 1'b0;
  logic rst_n, ce, prot, rd, wr;
  logic [3:0] addr, be;
  logic [31:0] wdata, flag_req, rdata, src_flag, irq_req;
  logic waitreq, irq, evt_irq;
  logic [31:0] seed = 32'hd6d18582;
  logic [31:0] en_m = 32'h0;
  logic [31:0] flag_m = 32'h0;
  logic [31:0] d;
  int mismatches = 0;
  int num_checks = 0;

  always #2 clk = ~clk;

  ocie_src_model ocie_src_model_i (.clk(clk), .flag_req(flag_req), .flag(src_flag));
  ocie_top ocie_top_i (.CLK(clk), .RST_N(rst_n), .CE(ce), .AVS_ADDRESS(addr),
    .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be),
    .AVS_READDATA(rdata), .AVS_WAITREQUEST(waitreq), .PROT_ACTIVE(prot),
    .SRC_FLAG(src_flag), .IRQ_REQ(irq_req), .IRQ(irq), .EVT_IRQ(evt_irq));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic err(input string m);
    mismatches++;
    $display("unexpected at %0t: %s", $time, m);
  endtask

  task automatic cmp_reg(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) err($sformatf("register %h, model %h", g, e));
  endtask

  task automatic cmp_irq();
    logic [31:0] e;
    e = en_m & flag_m & impl;
    num_checks++;
    if (irq_req !== e || irq !== (|e)) err($sformatf("requests %h, model %h", irq_req, e));
  endtask

  // Hold the request until waitrequest is seen low at an edge
  task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] dt,
                     input logic [3:0] b, output logic [31:0] q);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= dt;
    be <= b;
    do begin
      @(posedge clk);
    end while (waitreq !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wreg(input logic [3:0] a, input logic [31:0] dt, input logic [3:0] b);
    logic [31:0] m, q;
    m = {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
    acc(1'b1, a, dt, b, q);
    if (!prot && a == 4'h0) en_m &= ~(dt & m);
    if (!prot && a == 4'h4) en_m |= dt & m & impl;
  endtask

  task automatic rreg(input logic [3:0] a, input logic [31:0] e);
    logic [31:0] q;
    acc(1'b0, a, 32'h0, 4'hf, q);
    cmp_reg(q, e);
  endtask

  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    #100000;
    err("timeout");
    print_verdict();
  end

  initial begin
    rst_n = 1'b0; ce = 1'b1; prot = 1'b0; rd = 1'b0; wr = 1'b0;
    addr = 4'h0; be = 4'h0; wdata = 32'h0; flag_req = 32'h0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rreg(4'h0, 32'h0);
    rreg(4'h4, 32'h0);
    rreg(4'hc, 32'h0003_8fff);
    rreg(4'h6, 32'h0);
    $display("test reset done");
    wreg(4'h4, 32'hffff_ffff, 4'hf);
    rreg(4'h0, 32'h0003_8fff);
    wreg(4'h0, 32'hffff_ffff, 4'hf);
    rreg(4'h4, 32'h0);
    $display("test bit map done");
    for (int i = 0; i < 80; i++) begin
      seed = lfsr(seed);
      flag_req <= seed;
      flag_m = seed;
      seed = lfsr(seed);
      prot <= (seed[1:0] == 2'h0);
      d = lfsr(seed);
      if (seed[31]) d &= impl;
      wreg(seed[31] ? 4'h4 : 4'h0, d, seed[7:4]);
      repeat (3) @(posedge clk);
      cmp_irq();
      rreg(4'h0, en_m);
      rreg(4'h4, en_m);
    end
    prot <= 1'b0;
    $display("test random done");
    flag_req <= 32'h0;
    flag_m = 32'h0;
    wreg(4'h0, 32'hffff_ffff, 4'hf);
    repeat (3) @(posedge clk);
    wreg(4'h8, impl, 4'hf);
    rreg(4'h8, 32'h0);
    wreg(4'h4, 32'h0000_0400, 4'h2);
    flag_req <= 32'h0000_0500;
    flag_m = 32'h0000_0500;
    repeat (4) @(posedge clk);
    cmp_irq();
    rreg(4'h8, 32'h0000_0400);
    cmp_reg({31'h0, evt_irq}, 32'h1);
    flag_req <= 32'h0;
    flag_m = 32'h0;
    repeat (4) @(posedge clk);
    cmp_irq();
    rreg(4'h8, 32'h0000_0400);
    wreg(4'hc, 32'h0, 4'hf);
    repeat (2) @(posedge clk);
    cmp_reg({31'h0, evt_irq}, 32'h0);
    wreg(4'hc, impl, 4'hf);
    repeat (2) @(posedge clk);
    cmp_reg({31'h0, evt_irq}, 32'h1);
    wreg(4'h8, 32'h0000_0400, 4'h2);
    repeat (2) @(posedge clk);
    cmp_reg({31'h0, evt_irq}, 32'h0);
    rreg(4'h8, 32'h0);
    $display("test interrupt done");
    // Clock enable low freezes the requests
    wreg(4'h4, impl, 4'hf);
    flag_req <= impl;
    flag_m = impl;
    repeat (3) @(posedge clk);
    cmp_irq();
    ce <= 1'b0;
    flag_req <= 32'h0;
    repeat (3) @(posedge clk);
    cmp_irq();
    ce <= 1'b1;
    flag_m = 32'h0;
    repeat (3) @(posedge clk);
    cmp_irq();
    $display("test clock enable done");
    // Second reset in mid-run
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    en_m = 32'h0;
    @(posedge clk);
    rreg(4'h0, en_m);
    rreg(4'hc, impl);
    rreg(4'h8, 32'h0);
    cmp_irq();
    $display("test reset again done");
    print_verdict();
  end
endmodule
